// >>> encoder_readout_params.svh
// offsets, field positions, reset values and counts of the encoder readout
`ifndef ENCODER_READOUT_PARAMS_SVH
`define ENCODER_READOUT_PARAMS_SVH

`define ENC_OFS_CONTROL      12'h000
`define ENC_OFS_STATUS       12'h004
`define ENC_OFS_IRQ_ENABLE   12'h008
`define ENC_OFS_IRQ_CLEAR    12'h00c
`define ENC_OFS_POSITION     12'h010
`define ENC_OFS_LAST_COUNT   12'h014

`define ENC_CTRL_LINK_EN     0
`define ENC_RST_CONTROL      1'h1
`define ENC_RST_IRQ_ENABLE   3'h0

`define ENC_EV_WORD_DONE     0
`define ENC_EV_SHORT_WORD    1
`define ENC_EV_LIGHT_ALARM   2
`define ENC_EV_BITS          3

`define ENC_WORD_BITS        16
`define ENC_SHORT_MIN_BITS   5'h0c
`define ENC_FULL_BITS        5'h10
`define ENC_CORR_BIT         4
`define ENC_PIN_IDLE         25'h1a00000

`endif

// >>> encoder_readout_pkg.sv
// types shared by the encoder serial readout
`default_nettype none
package encoder_readout_pkg;

    typedef struct packed {
        logic shift_load_select;
        logic shift_clock;
        logic cascade_data_in;
    } link_pins_t;

    typedef struct packed {
        logic code_correction_enable;
        logic direction_invert;
    } option_pins_t;

    typedef struct packed {
        logic        light_sense_low;
        logic        illum_overdrive;
        logic        sine_track;
        logic        cosine_track;
        logic [15:0] position_word;
    } optic_pins_t;

    typedef enum logic [1:0] {
        ST_LOAD,
        ST_SHIFT,
        ST_DONE
    } link_state_t;

endpackage
`default_nettype wire

// >>> pin_sync.sv
// two flip-flop synchroniser, one per bit
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    meta_r[i]   <= RST_VAL[i];
                    sync_out[i] <= RST_VAL[i];
                end else begin
                    meta_r[i]   <= async_in[i];
                    sync_out[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> encoder_serial_position_readout.sv
// serial position readout with apb status and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "encoder_readout_params.svh"

// Behaviour
// R1: select high loads, low shifts on clock
// R2: each shift clock presents next word bit
// R3: host samples data at clock falling edge
// R4: word leaves top bit first, then downward
// R5: load mode shows top bit continuously
// R6: host gives sixteen clocks for full word
// R7: twelve to fifteen clocks give upper bits
// R8: host clock at most sixteen megahertz
// R9: invert flips top bit, still sent first
// R10: code correction acts on twelve-bit word
// R11: alarm high on low light with overdrive
// R12: digitised sine and cosine tracks output
// R13: host holds probe low, probe clock open
// R14: correction enable high activates correction
// R15: invert high inverts most significant bit
// R16: cascade input feeds shift register serially
// R17: word captured in load, frozen while shifting
// R18: register advances on shift clock rising edge
module encoder_serial_position_readout (
    input  wire logic                               ref_clk,
    input  wire logic                               srst,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [11:0]                        paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    output logic                                    irq,
    input  wire encoder_readout_pkg::link_pins_t    link_pins,
    input  wire encoder_readout_pkg::option_pins_t  option_pins,
    input  wire encoder_readout_pkg::optic_pins_t   optic_pins,
    output logic                                    serial_data_out,
    output logic                                    light_low_alarm,
    output logic                                    sine_track_digital,
    output logic                                    cosine_track_digital
);
    import encoder_readout_pkg::*;

    localparam int SW = $bits(link_pins_t) + $bits(option_pins_t) + $bits(optic_pins_t);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SW-1:0] pins_s;
    link_pins_t    link_s;
    option_pins_t  opt_s;
    optic_pins_t   optic_s;

    pin_sync #(
        .W        (SW),
        .RST_VAL  (`ENC_PIN_IDLE)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in ({link_pins, option_pins, optic_pins}),
        .sync_out (pins_s)
    );

    assign {link_s, opt_s, optic_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////////
    // shift clock edge detect

    logic sclk_d_r;
    logic sclk_rise;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= link_s.shift_clock;
        end
    end

    assign sclk_rise = link_s.shift_clock & ~sclk_d_r; // R18

    ////////////////////////////////////////////////////////////////////////////
    // position word composition

    logic [15:0] word_nxt;
    logic        fine_parity;

    assign fine_parity = optic_s.sine_track ^ optic_s.cosine_track;

    always_comb begin
        word_nxt = optic_s.position_word;
        if (opt_s.code_correction_enable) begin
            word_nxt[`ENC_CORR_BIT] = optic_s.position_word[`ENC_CORR_BIT] ^ fine_parity; // R10 R14
        end
        word_nxt[`ENC_WORD_BITS-1] = word_nxt[`ENC_WORD_BITS-1] ^ opt_s.direction_invert; // R9 R15
    end

    ////////////////////////////////////////////////////////////////////////////
    // link state machine and shift register

    link_state_t state_r;
    logic [15:0] shreg_r;
    logic [4:0]  count_r;
    logic [4:0]  last_count_r;
    logic [15:0] position_r;
    logic [15:0] frame_word_r;
    logic        link_en_r;
    logic        ev_word_done;
    logic        ev_short_word;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_LOAD;
        end else begin
            case (state_r)
                ST_LOAD: begin
                    if (!link_s.shift_load_select && link_en_r) begin // R1
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (link_s.shift_load_select) begin
                        state_r <= ST_LOAD;
                    end else if (sclk_rise && count_r == `ENC_FULL_BITS - 5'h01) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (link_s.shift_load_select) begin
                        state_r <= ST_LOAD;
                    end
                end
                default: begin
                    state_r <= ST_LOAD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            shreg_r <= 16'h0000;
        end else if (state_r == ST_LOAD) begin
            shreg_r <= word_nxt; // R17
        end else if (sclk_rise && !link_s.shift_load_select) begin
            shreg_r <= {shreg_r[14:0], link_s.cascade_data_in}; // R2 R16 R18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_word_r <= 16'h0000;
        end else if (state_r == ST_LOAD) begin
            frame_word_r <= word_nxt; // R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_r <= 5'h00;
        end else if (state_r == ST_LOAD) begin
            count_r <= 5'h00;
        end else if (state_r == ST_SHIFT && sclk_rise && !link_s.shift_load_select) begin
            count_r <= count_r + 5'h01;
        end
    end

    assign ev_word_done  = state_r == ST_SHIFT && sclk_rise && !link_s.shift_load_select
                           && count_r == `ENC_FULL_BITS - 5'h01;
    assign ev_short_word = state_r == ST_SHIFT && link_s.shift_load_select
                           && count_r >= `ENC_SHORT_MIN_BITS; // R7

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_count_r <= 5'h00;
            position_r   <= 16'h0000;
        end else if (ev_word_done) begin
            last_count_r <= `ENC_FULL_BITS;
            position_r   <= frame_word_r;
        end else if (ev_short_word) begin
            last_count_r <= count_r;
            position_r   <= frame_word_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            serial_data_out <= 1'b0;
        end else if (state_r == ST_LOAD) begin
            serial_data_out <= word_nxt[`ENC_WORD_BITS-1]; // R5
        end else begin
            serial_data_out <= shreg_r[`ENC_WORD_BITS-1]; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm and test tracks

    logic alarm_nxt;

    assign alarm_nxt = optic_s.light_sense_low & optic_s.illum_overdrive;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            light_low_alarm      <= 1'b0;
            sine_track_digital   <= 1'b0;
            cosine_track_digital <= 1'b0;
        end else begin
            light_low_alarm      <= alarm_nxt; // R11
            sine_track_digital   <= optic_s.sine_track; // R12
            cosine_track_digital <= optic_s.cosine_track; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic [31:0] rd_nxt;
    logic [2:0]  status_r;
    logic [2:0]  irq_en_r;
    logic [2:0]  ev_set;

    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & ~penable;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `ENC_OFS_CONTROL:    rd_nxt = {31'h0, link_en_r};
            `ENC_OFS_STATUS:     rd_nxt = {29'h0, status_r};
            `ENC_OFS_IRQ_ENABLE: rd_nxt = {29'h0, irq_en_r};
            `ENC_OFS_IRQ_CLEAR:  rd_nxt = 32'h0000_0000;
            `ENC_OFS_POSITION:   rd_nxt = {16'h0, position_r};
            `ENC_OFS_LAST_COUNT: rd_nxt = {27'h0, last_count_r};
            default:             mapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (rd_en) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link_en_r <= `ENC_RST_CONTROL;
            irq_en_r  <= `ENC_RST_IRQ_ENABLE;
        end else if (wr_en && paddr == `ENC_OFS_CONTROL) begin
            link_en_r <= pwdata[`ENC_CTRL_LINK_EN];
        end else if (wr_en && paddr == `ENC_OFS_IRQ_ENABLE) begin
            irq_en_r  <= pwdata[`ENC_EV_BITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events and interrupt

    logic [2:0] clr;

    assign ev_set[`ENC_EV_WORD_DONE]   = ev_word_done;
    assign ev_set[`ENC_EV_SHORT_WORD]  = ev_short_word;
    assign ev_set[`ENC_EV_LIGHT_ALARM] = alarm_nxt & ~light_low_alarm;
    assign clr = (wr_en && paddr == `ENC_OFS_IRQ_CLEAR) ? pwdata[`ENC_EV_BITS-1:0] : 3'h0;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_r <= 3'h0;
            irq      <= 1'b0;
        end else begin
            status_r <= (status_r & ~clr) | ev_set;
            irq      <= |(((status_r & ~clr) | ev_set) & irq_en_r);
        end
    end

endmodule

`default_nettype wire

// >>> host_link_model.sv
// host controller model reading the serial position word
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    output var encoder_readout_pkg::link_pins_t link_pins,
    input  wire logic                           serial_data_out
);
    import encoder_readout_pkg::*;
    initial begin
        link_pins = '{1'b1, 1'b1, 1'b0};
    end
    task automatic read_word(input int n, input logic cin, output logic [31:0] w);
        w = 32'h0;
        #1;
        link_pins.cascade_data_in = cin;
        link_pins.shift_load_select = 1'b1;
        #200;
        link_pins.shift_load_select = 1'b0;
        #62.5;
        repeat (n) begin
            w = {w[30:0], serial_data_out};
            link_pins.shift_clock = 1'b0;
            #62.5;
            link_pins.shift_clock = 1'b1;
            #62.5;
        end
        link_pins.shift_load_select = 1'b1;
        link_pins.cascade_data_in = ~cin;
    endtask
endmodule
`default_nettype wire

// >>> encoder_readout_chk_sva.sv
// port assertions of the encoder serial readout
`timescale 1ns/10ps
`default_nettype none
module encoder_readout_chk (
    input wire logic                              ref_clk,
    input wire logic                              srst,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [31:0]                       prdata,
    input wire logic                              pready,
    input wire logic                              pslverr,
    input wire encoder_readout_pkg::link_pins_t   link_pins,
    input wire encoder_readout_pkg::option_pins_t option_pins,
    input wire encoder_readout_pkg::optic_pins_t  optic_pins,
    input wire logic                              serial_data_out,
    input wire logic                              light_low_alarm,
    input wire logic                              sine_track_digital,
    input wire logic                              cosine_track_digital
);
    import encoder_readout_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic       dim;
    logic [6:0] clk_hist;
    assign dim = optic_pins.light_sense_low & optic_pins.illum_overdrive;
    always_ff @(posedge ref_clk) begin
        clk_hist <= {clk_hist[5:0], link_pins.shift_clock};
    end
    ////////////////////////////////////////////////////////////
    a_alarm_rise: assert property (dim [*4] |=> light_low_alarm)
        else $error("alarm stayed low");
    a_alarm_fall: assert property (!dim [*4] |=> !light_low_alarm)
        else $error("alarm stayed high");
    a_tracks_copy: assert property ($stable({optic_pins.sine_track, optic_pins.cosine_track}) [*4]
        |=> {sine_track_digital, cosine_track_digital} == $past({optic_pins.sine_track, optic_pins.cosine_track}))
        else $error("track outputs wrong");
    a_load_top_bit: assert property ((link_pins.shift_load_select && $stable(optic_pins.position_word[15])
        && $stable(option_pins.direction_invert)) [*6]
        |=> serial_data_out == $past(optic_pins.position_word[15] ^ option_pins.direction_invert))
        else $error("load output not top bit");
    a_bit_after_clock: assert property ((!link_pins.shift_load_select) [*8]
        ##1 (!link_pins.shift_load_select && $changed(serial_data_out)) |-> |(clk_hist[5:2] & ~clk_hist[6:3]))
        else $error("data moved without clock rise");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    c_unmapped: cover property (pready && pslverr);
    c_alarm: cover property ($rose(light_low_alarm));
    c_shift_bit: cover property (!link_pins.shift_load_select && $changed(serial_data_out));
endmodule

bind encoder_serial_position_readout encoder_readout_chk chk (.ref_clk, .srst, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .link_pins, .option_pins, .optic_pins, .serial_data_out, .light_low_alarm,
    .sine_track_digital, .cosine_track_digital);
`default_nettype wire

// >>> encoder_serial_position_readout_tb.sv
// self-checking bench of the encoder serial readout
`timescale 1ns/10ps
`default_nettype none
`include "encoder_readout_params.svh"
module encoder_serial_position_readout_tb;
    import encoder_readout_pkg::*;
    logic         ref_clk;
    logic         srst;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         irq;
    link_pins_t   link_pins;
    option_pins_t option_pins;
    optic_pins_t  optic_pins;
    logic         serial_data_out;
    logic         light_low_alarm;
    logic         sine_track_digital;
    logic         cosine_track_digital;
    logic [31:0]  q;
    logic         e;
    int           error_cnt;
    int           n_tests;

    encoder_serial_position_readout dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .link_pins, .option_pins, .optic_pins, .serial_data_out, .light_low_alarm,
        .sine_track_digital, .cosine_track_digital);
    host_link_model host (.link_pins, .serial_data_out);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), ex, q);
    endtask
    task automatic frame(input int n, input logic inv, input logic corr, input logic sn, input logic cs,
        input logic [15:0] pos, input logic cin);
        logic [15:0] ex;
        logic [31:0] w;
        @(posedge ref_clk);
        option_pins <= '{corr, inv};
        optic_pins.sine_track    <= sn;
        optic_pins.cosine_track  <= cs;
        optic_pins.position_word <= pos;
        ex = pos;
        ex[4] = ex[4] ^ (corr & (sn ^ cs));
        ex[15] = ex[15] ^ inv;
        host.read_word(n, cin, w);
        chk("word", {ex, {16{cin}}} >> (32 - n), w);
        repeat (6) @(posedge ref_clk);
        rd(`ENC_OFS_POSITION, {16'h0, ex});
        rd(`ENC_OFS_LAST_COUNT, (n < 16) ? 32'(n) : 32'h10);
        apb(1'b1, `ENC_OFS_IRQ_CLEAR, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(`ENC_OFS_CONTROL, 32'h1);
        apb(1'b1, `ENC_OFS_CONTROL, 32'h0);
        rd(`ENC_OFS_CONTROL, 32'h0);
        apb(1'b1, `ENC_OFS_CONTROL, 32'h1);
        rd(`ENC_OFS_IRQ_ENABLE, 32'h0);
        apb(1'b1, `ENC_OFS_IRQ_ENABLE, 32'h7);
        rd(`ENC_OFS_IRQ_ENABLE, 32'h7);
        rd(12'h0f0, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
    endtask
    task automatic t_full;
        frame(16, 1'b0, 1'b1, 1'b0, 1'b0, 16'ha5c3, 1'b0);
        rd(`ENC_OFS_STATUS, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, `ENC_OFS_IRQ_CLEAR, 32'h7);
        rd(`ENC_OFS_STATUS, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_short;
        for (int n = 12; n < 16; n++) begin
            frame(n, 1'b0, 1'b1, 1'b0, 1'b0, 16'hc3a5, 1'b0);
        end
        rd(`ENC_OFS_STATUS, 32'h2);
        apb(1'b1, `ENC_OFS_IRQ_CLEAR, 32'h7);
    endtask
    task automatic t_corr;
        frame(16, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0f0f, 1'b0);
        chk("sine", 32'h1, {31'h0, sine_track_digital});
        frame(16, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0f0f, 1'b0);
        chk("cosine", 32'h1, {31'h0, cosine_track_digital});
    endtask
    task automatic t_cascade;
        frame(17, 1'b1, 1'b0, 1'b0, 1'b0, 16'h00ff, 1'b1);
        apb(1'b1, `ENC_OFS_IRQ_CLEAR, 32'h7);
    endtask
    task automatic t_alarm;
        optic_pins.light_sense_low <= 1'b1;
        optic_pins.illum_overdrive <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("alarm", 32'h1, {31'h0, light_low_alarm});
        rd(`ENC_OFS_STATUS, 32'h4);
        apb(1'b1, `ENC_OFS_IRQ_CLEAR, 32'h7);
        optic_pins.light_sense_low <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("alarm", 32'h0, {31'h0, light_low_alarm});
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim;
    end
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        option_pins = '{1'b1, 1'b0};
        optic_pins = '0;
        error_cnt = 0;
        n_tests = 0;
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs;
        t_full;
        t_short;
        t_corr;
        t_cascade;
        t_alarm;
        end_sim;
    end
endmodule
`default_nettype wire
